// ---- inc/adspi_pkg.sv ----
package adspi_pkg;

    // ----------------------------------------------------------------
    // Status byte layout
    // ----------------------------------------------------------------
    localparam int STAT_SRC_BIT   = 7;
    localparam int STAT_LIN_BIT   = 6;
    localparam int STAT_OV_BIT    = 5;
    localparam int STAT_UV_BIT    = 4;
    localparam int STAT_VREG_BIT  = 3;
    localparam int STAT_HS_BIT    = 2;
    localparam int STAT_WK2_BIT   = 1;
    localparam int STAT_WK1_BIT   = 0;

    // ----------------------------------------------------------------
    // Control byte layout and values
    // ----------------------------------------------------------------
    localparam int CTRL_SLOPE_HI  = 7;
    localparam int CTRL_SLOPE_LO  = 6;
    localparam int CTRL_PULLUP    = 5;
    localparam int CTRL_HS3       = 4;
    localparam int CTRL_HS2       = 3;
    localparam int CTRL_HS1       = 2;
    localparam int CTRL_MODE_HI   = 1;
    localparam int CTRL_MODE_LO   = 0;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] STOP_CMD_MASK  = 8'hdf;
    localparam logic [7:0] STOP_CMD_VALUE = 8'hc1;
    localparam logic [1:0] MODE_NORMAL_REQ = 2'h0;
    localparam logic [1:0] MODE_NORMAL     = 2'h2;
    localparam logic [3:0] BIT_COUNT_FULL  = 4'h8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CORE_CLK_HZ          = 20_000_000;
    localparam int WAKE_DOM_MIN_NS      = 30_000;
    localparam int WAKE_DOM_MIN_CYCLES  =
        (WAKE_DOM_MIN_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OPM_NORMAL_REQ,
        OPM_NORMAL,
        OPM_STOP
    } adspi_mode_type;

    typedef struct packed {
        logic over_voltage;
        logic under_voltage;
        logic vreg_hot;
        logic hs_hot;
        logic lin_overcurrent;
        logic lin_fet_hot;
        logic wake_in_one;
        logic wake_in_two;
    } adspi_sense_type;

    typedef struct packed {
        logic       lin_tx_enable;
        logic       lin_drive_low;
        logic       pullup_connect;
        logic [2:0] highside_on;
        logic [1:0] slope;
    } adspi_drive_type;

endpackage

// ---- logic/adspi_core.sv ----
`timescale 1ns/1ps
module adspi_core
    import adspi_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_DOM_MIN_CYCLES
)(
    input  wire logic            i_core_clk,
    input  wire logic            i_rst,
    input  wire logic            i_sck,
    input  wire logic            i_ss_n,
    input  wire logic            i_mosi,
    output logic                 o_miso,
    output logic                 o_miso_oe,
    input  wire logic            i_tx_drive_pin,
    input  wire logic            i_lin_bus,
    output logic                 o_rx_sense_pin,
    input  wire adspi_pkg::adspi_sense_type i_sense,
    output adspi_pkg::adspi_drive_type      o_drive,
    output logic                 o_irq_n
);
    import adspi_pkg::*;

    // ----------------------------------------------------------------
    // Link domain: shift register on the serial clock
    // ----------------------------------------------------------------
    logic [7:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic [7:0] tx_snap_q;
    logic [7:0] rx_word_q;
    logic       rx_valid_q;
    logic       done_tgl_q;
    logic       start_tgl_q;
    logic [7:0] status_live;

    // Sample MOSI on falling clock edge, MSB first
    always_ff @(negedge i_sck or posedge i_ss_n)
    begin
        if (i_ss_n)
        begin
            rx_cnt_q <= 4'h0;
            rx_sh_q  <= 8'h00;
        end
        else
        begin
            rx_sh_q  <= {rx_sh_q[6:0], i_mosi};
            if (rx_cnt_q != 4'hf)
                rx_cnt_q <= rx_cnt_q + 4'h1;
        end
    end

    // Status snapshot taken at select fall
    always_ff @(negedge i_ss_n or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_snap_q   <= 8'h00;
            start_tgl_q <= 1'b0;
        end
        else
        begin
            tx_snap_q   <= status_live;
            start_tgl_q <= ~start_tgl_q;
        end
    end

    // Commit at select rise, valid only with eight samples
    always_ff @(posedge i_ss_n or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_word_q  <= CTRL_RESET;
            rx_valid_q <= 1'b0;
            done_tgl_q <= 1'b0;
        end
        else
        begin
            rx_word_q  <= rx_sh_q;
            rx_valid_q <= (rx_cnt_q == BIT_COUNT_FULL);
            done_tgl_q <= ~done_tgl_q;
        end
    end

    // Rising clock edges counted since select fell
    logic [3:0] rise_cnt_q;
    always_ff @(posedge i_sck or posedge i_ss_n)
    begin
        if (i_ss_n)
            rise_cnt_q <= 4'h0;
        else if (rise_cnt_q != 4'hf)
            rise_cnt_q <= rise_cnt_q + 4'h1;
    end

    // Outgoing bit: D7 until the second rising edge, next bit after each later rising edge
    logic [3:0] tx_pos;
    logic       tx_bit;
    always_comb
    begin
        tx_pos = BIT_COUNT_FULL - rise_cnt_q;
        if (rise_cnt_q == 4'h0)
            tx_bit = tx_snap_q[7];
        else if (rise_cnt_q > BIT_COUNT_FULL)
            tx_bit = 1'b1;
        else
            tx_bit = tx_snap_q[tx_pos[2:0]];
    end

    // Output bit and enable; released while deselected
    assign o_miso    = i_ss_n ? 1'b1 : tx_bit;
    assign o_miso_oe = ~i_ss_n;

    // ----------------------------------------------------------------
    // Crossing into core domain
    // ----------------------------------------------------------------
    logic [2:0] done_sync_q;
    logic [2:0] start_sync_q;
    logic [1:0] lin_sync_q;
    logic [1:0] txd_sync_q;
    logic       done_evt;
    logic       start_evt;
    adspi_sense_type sense_meta_q;
    adspi_sense_type sense_s;

    // Toggle synchronisers and pin synchronisers
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            done_sync_q  <= 3'h0;
            start_sync_q <= 3'h0;
            lin_sync_q   <= 2'h3;
            txd_sync_q   <= 2'h3;
            sense_meta_q <= '0;
            sense_s      <= '0;
        end
        else
        begin
            sense_meta_q <= i_sense;
            sense_s      <= sense_meta_q;
            done_sync_q  <= {done_sync_q[1:0], done_tgl_q};
            start_sync_q <= {start_sync_q[1:0], start_tgl_q};
            lin_sync_q   <= {lin_sync_q[0], i_lin_bus};
            txd_sync_q   <= {txd_sync_q[0], i_tx_drive_pin};
        end
    end
    assign done_evt  = done_sync_q[2] ^ done_sync_q[1];
    assign start_evt = start_sync_q[2] ^ start_sync_q[1];

    // ----------------------------------------------------------------
    // Core domain: control, flags, LIN
    // ----------------------------------------------------------------
    logic [7:0]     ctrl_q;
    adspi_mode_type mode_q;
    logic           stop_seen_q;
    logic           lin_flag_q;
    logic           lin_fault_q;
    logic           hs_lock_q;
    logic           src_q;
    logic [1:0]     wake_src_q;
    logic           read_pend_q;
    logic [7:0]     read_snap_q;
    logic           lin_bad;
    logic           stop_cmd;
    logic [WAKE_CYCLES > 1 ? $clog2(WAKE_CYCLES + 1) - 1 : 0:0] dom_cnt_q;
    logic           dom_long_q;
    logic           lin_prev_q;
    logic           wake_lin;
    logic [1:0]     wk_prev_q;
    logic           wake_pin;
    logic [3:0]     cond_prev_q;
    logic           irq_evt;
    logic           irq_q;
    logic           read_done;

    assign lin_bad   = sense_s.lin_overcurrent | sense_s.lin_fet_hot;
    assign stop_cmd  = (rx_word_q & STOP_CMD_MASK) == STOP_CMD_VALUE;
    assign read_done = done_evt & rx_valid_q;

    // Live status: source bit selects event source or real time view of the two wake bits
    always_comb
    begin
        status_live = 8'h00;
        status_live[STAT_SRC_BIT]  = src_q;
        status_live[STAT_LIN_BIT]  = lin_flag_q;
        status_live[STAT_OV_BIT]   = sense_s.over_voltage;
        status_live[STAT_UV_BIT]   = sense_s.under_voltage;
        status_live[STAT_VREG_BIT] = sense_s.vreg_hot;
        status_live[STAT_HS_BIT]   = sense_s.hs_hot | hs_lock_q;
        status_live[STAT_WK2_BIT]  = src_q ? wake_src_q[1] : sense_s.wake_in_two;
        status_live[STAT_WK1_BIT]  = src_q ? wake_src_q[0] : sense_s.wake_in_one;
    end

    // Snapshot seen by master, captured per transfer start
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            read_pend_q <= 1'b0;
            read_snap_q <= 8'h00;
        end
        else if (start_evt)
        begin
            read_pend_q <= 1'b1;
            read_snap_q <= tx_snap_q;
        end
        else if (read_done)
            read_pend_q <= 1'b0;
    end

    // Control register and mode, stop needs two stop bytes
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_q      <= CTRL_RESET;
            mode_q      <= OPM_NORMAL_REQ;
            stop_seen_q <= 1'b0;
        end
        else if (mode_q == OPM_STOP && (wake_lin || wake_pin))
            mode_q <= OPM_NORMAL_REQ;
        else if (read_done)
        begin
            ctrl_q      <= rx_word_q;
            stop_seen_q <= stop_cmd;
            if (stop_cmd && stop_seen_q)
                mode_q <= OPM_STOP;
            else if (rx_word_q[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_NORMAL)
                mode_q <= OPM_NORMAL;
            else if (rx_word_q[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_NORMAL_REQ)
                mode_q <= OPM_NORMAL_REQ;
        end
    end

    // LIN fault latch and clear-on-read; set wins over clear
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lin_flag_q  <= 1'b0;
            lin_fault_q <= 1'b0;
        end
        else
        begin
            if (lin_bad)
                lin_fault_q <= 1'b1;
            else if (!lin_flag_q)
                lin_fault_q <= 1'b0;
            if (lin_bad || wake_lin)
                lin_flag_q <= 1'b1;
            else if (read_done && read_snap_q[STAT_LIN_BIT])
                lin_flag_q <= 1'b0;
        end
    end

    // High side lock: cleared by read of flag, then enable write
    logic hs_read_q;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            hs_lock_q <= 1'b0;
            hs_read_q <= 1'b0;
        end
        else if (sense_s.hs_hot)
        begin
            hs_lock_q <= 1'b1;
            hs_read_q <= 1'b0;
        end
        else if (read_done && hs_lock_q)
        begin
            if (hs_read_q && (rx_word_q[CTRL_HS3:CTRL_HS1] != 3'h0))
                hs_lock_q <= 1'b0;
            hs_read_q <= read_snap_q[STAT_HS_BIT] | hs_read_q;
        end
    end

    // Wake detection: long dominant then rising edge, and pin change
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dom_cnt_q  <= '0;
            dom_long_q <= 1'b0;
            lin_prev_q <= 1'b1;
            wk_prev_q  <= 2'h0;
        end
        else
        begin
            lin_prev_q <= lin_sync_q[1];
            wk_prev_q  <= {sense_s.wake_in_two, sense_s.wake_in_one};
            if (lin_sync_q[1])
            begin
                dom_cnt_q  <= '0;
                dom_long_q <= 1'b0;
            end
            else if (dom_cnt_q == WAKE_CYCLES[$bits(dom_cnt_q)-1:0])
                dom_long_q <= 1'b1;
            else
                dom_cnt_q <= dom_cnt_q + 1'b1;
        end
    end
    assign wake_lin = (mode_q == OPM_STOP) & dom_long_q & lin_sync_q[1] & ~lin_prev_q;
    assign wake_pin = (mode_q == OPM_STOP) &
                      (wk_prev_q != {sense_s.wake_in_two, sense_s.wake_in_one});

    // Event source indicator, sent once then cleared; set wins
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            src_q      <= 1'b0;
            wake_src_q <= 2'h0;
        end
        else if (irq_evt)
        begin
            src_q <= 1'b1;
            if (wake_pin)
                wake_src_q <= wk_prev_q ^ {sense_s.wake_in_two, sense_s.wake_in_one};
        end
        else if (read_done && read_snap_q[STAT_SRC_BIT])
        begin
            src_q      <= 1'b0;
            wake_src_q <= 2'h0;
        end
    end

    // Interrupt pulse on rising LIN fault or wake, or on rising supply or thermal fault outside stop mode
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cond_prev_q <= 4'h0;
            irq_q       <= 1'b0;
        end
        else
        begin
            cond_prev_q <= {sense_s.over_voltage, sense_s.under_voltage,
                            sense_s.vreg_hot, sense_s.hs_hot};
            irq_q       <= irq_evt;
        end
    end
    assign irq_evt = ((mode_q != OPM_STOP) &
                      (|({sense_s.over_voltage, sense_s.under_voltage,
                          sense_s.vreg_hot, sense_s.hs_hot} & ~cond_prev_q)))
                     | (lin_bad & ~lin_fault_q) | wake_lin | wake_pin;

    // Pin outputs from flops
    logic tx_en;
    assign tx_en = (mode_q == OPM_NORMAL || mode_q == OPM_NORMAL_REQ) & ~lin_fault_q;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_drive        <= '0;
            o_rx_sense_pin <= 1'b1;
            o_irq_n        <= 1'b1;
        end
        else
        begin
            o_drive.lin_tx_enable  <= tx_en & ~lin_bad;
            o_drive.lin_drive_low  <= tx_en & ~lin_bad & ~txd_sync_q[1];
            o_drive.pullup_connect <= ~ctrl_q[CTRL_PULLUP];
            o_drive.highside_on    <= (mode_q == OPM_STOP || hs_lock_q || sense_s.hs_hot) ?
                                      3'h0 : ctrl_q[CTRL_HS3:CTRL_HS1];
            o_drive.slope          <= ctrl_q[CTRL_SLOPE_HI:CTRL_SLOPE_LO];
            o_rx_sense_pin         <= lin_sync_q[1];
            o_irq_n                <= ~irq_q;
        end
    end

endmodule

// ---- bench/adspi_core_sva.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the serial and LIN core
// ----------------------------------------
module adspi_core_sva
    import adspi_pkg::*;
(
    input wire logic                       i_core_clk,
    input wire logic                       i_rst,
    input wire logic                       i_ss_n,
    input wire logic                       o_miso_oe,
    input wire logic                       i_tx_drive_pin,
    input wire logic                       i_lin_bus,
    input wire logic                       o_rx_sense_pin,
    input wire adspi_pkg::adspi_sense_type i_sense,
    input wire adspi_pkg::adspi_drive_type o_drive,
    input wire logic                       o_irq_n
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    // Output driver follows select
    AST_MISO_RELEASE: assert property (i_ss_n |-> !o_miso_oe)
        else $error("miso driven while deselected");
    AST_MISO_DRIVE: assert property (!i_ss_n |-> o_miso_oe)
        else $error("miso idle while selected");
    // Faults switch drivers off
    AST_LIN_FAULT_OFF: assert property (i_sense.lin_overcurrent [*4] |-> !o_drive.lin_tx_enable)
        else $error("transmitter on during lin fault");
    AST_HS_OFF: assert property (i_sense.hs_hot [*4] |-> o_drive.highside_on == 3'h0)
        else $error("high side on during thermal fault");
    // Transmit and receive levels
    AST_TX_LOW: assert property ((o_drive.lin_tx_enable && !i_tx_drive_pin) [*4]
        |-> o_drive.lin_drive_low)
        else $error("bus not dominant for low transmit pin");
    AST_TX_HIGH: assert property (i_tx_drive_pin [*4] |-> !o_drive.lin_drive_low)
        else $error("bus dominant for high transmit pin");
    AST_RX_LEVEL: assert property ($stable(i_lin_bus) [*4] |-> o_rx_sense_pin == i_lin_bus)
        else $error("receive pin differs from bus");
    // Control and interrupt timing
    AST_CTRL_HOLD: assert property (i_ss_n [*8] |-> $stable(o_drive.slope))
        else $error("control changed without transfer");
    AST_OV_IRQ: assert property ($rose(i_sense.over_voltage) && o_drive.lin_tx_enable
        |-> ##[1:6] !o_irq_n)
        else $error("no interrupt for overvoltage");
    AST_IRQ_PULSE: assert property ($fell(o_irq_n) |=> o_irq_n)
        else $error("interrupt pulse too long");

    // Main scenarios reached
    COV_IRQ: cover property ($fell(o_irq_n));
    COV_FRAME: cover property ($rose(i_ss_n));
    COV_TX_OFF: cover property ($fell(o_drive.lin_tx_enable));
endmodule

// ---- bench/adspi_master.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Serial master of the controller side
// ----------------------------------------
module adspi_master (
    output logic      o_sck,
    output logic      o_ss_n,
    output logic      o_mosi,
    input  wire logic i_miso,
    input  wire logic i_miso_oe
);
    // Idle: clock still, select high
    initial
    begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
        o_mosi = 1'b0;
    end

    // One framed transfer of n clocks, MSB first
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        o_ss_n = 1'b0;
        o_mosi = tx[7];
        #40;
        for (int k = 0; k < n; k++)
        begin
            o_sck = 1'b1;
            o_mosi = tx[(7 - k) & 7];
            #16;
            o_sck = 1'b0;
            rx = {rx[6:0], (i_miso_oe === 1'b1) ? i_miso : 1'bx};
            #16;
        end
        o_ss_n = 1'b1;
        o_mosi = ~o_mosi; // Released line shows no stale value
        #300;
    endtask
endmodule

// ---- bench/adspi_core_test.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the serial and LIN core
// ----------------------------------------
module adspi_core_test;
    import adspi_pkg::*;
    localparam int WAKE_N = 8;
    logic            clk;
    logic            rst;
    logic            sck;
    logic            ss_n;
    logic            mosi;
    logic            miso;
    logic            miso_oe;
    logic            tx_pin;
    logic            lin_bus;
    logic            rx_sense;
    adspi_sense_type sense;
    adspi_drive_type drive;
    logic            irq_n;
    logic [31:0]     seed;
    logic [31:0]     r;
    logic [7:0]      st;
    logic [7:0]      ctrl_m;
    int              err_count;
    int              n_checks;
    int              cyc;
    int              irq_seen;
    int              n0;

    adspi_core #(.WAKE_CYCLES(WAKE_N)) DUT (
        .i_core_clk(clk), .i_rst(rst), .i_sck(sck), .i_ss_n(ss_n), .i_mosi(mosi),
        .o_miso(miso), .o_miso_oe(miso_oe), .i_tx_drive_pin(tx_pin), .i_lin_bus(lin_bus),
        .o_rx_sense_pin(rx_sense), .i_sense(sense), .o_drive(drive), .o_irq_n(irq_n)
    );
    adspi_master u_mst (
        .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi), .i_miso(miso), .i_miso_oe(miso_oe)
    );

    // Core clock, 50 ns
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Interrupt pulse count and hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (irq_n === 1'b0)
            irq_seen <= irq_seen + 1;
        if (cyc == 20000)
        begin
            err_count = err_count + 1;
            finish_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Drive outputs against the control model
    task automatic chk_drv(input logic txe);
        repeat (2) @(posedge clk);
        chk(drive, {txe, 1'b0, ~ctrl_m[5], ctrl_m[4:2], ctrl_m[7:6]});
    endtask

    task automatic wr(input logic [7:0] c);
        repeat (4) @(posedge clk);
        u_mst.xfer(c, 8, st);
        ctrl_m = c;
    endtask

    task automatic chk_irq();
        repeat (8) @(posedge clk);
        chk(8'(irq_seen - n0), 8'h01);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        seed = 32'h373c;
        err_count = 0;
        n_checks = 0;
        cyc = 0;
        irq_seen = 0;
        rst = 1'b1;
        tx_pin = 1'b1;
        lin_bus = 1'b1;
        sense = '0;
        ctrl_m = CTRL_RESET;
        repeat (4) @(posedge clk);
        chk(drive, 8'h00);
        chk({5'h0, irq_n, rx_sense, miso_oe}, 8'h06);
        rst <= 1'b0;
        chk_drv(1'b1);
        // Random control bytes, live wake levels
        for (int i = 0; i < 6; i++)
        begin
            r = rnd();
            sense.wake_in_one <= r[8];
            sense.wake_in_two <= r[9];
            wr({r[7:2], r[1], 1'b0});
            chk_drv(1'b1);
            wr(ctrl_m);
            chk(st, {6'h0, r[9], r[8]});
        end
        $display("end of random control");
        sense <= '0;
        u_mst.xfer(8'h3c, 7, st);
        chk_drv(1'b1);
        u_mst.xfer(8'h3c, 9, st);
        chk_drv(1'b1);
        $display("end of bad frames");
        tx_pin <= 1'b0;
        lin_bus <= 1'b0;
        repeat (6) @(posedge clk);
        chk({6'h0, drive.lin_drive_low, rx_sense}, 8'h02);
        tx_pin <= 1'b1;
        lin_bus <= 1'b1;
        repeat (6) @(posedge clk);
        chk({6'h0, drive.lin_drive_low, rx_sense}, 8'h01);
        $display("end of transmit and receive");
        n0 = irq_seen;
        sense.lin_overcurrent <= 1'b1;
        repeat (6) @(posedge clk);
        sense.lin_overcurrent <= 1'b0;
        chk_irq();
        chk(drive.lin_tx_enable, 8'h00);
        wr(ctrl_m);
        chk(st, 8'hc0);
        chk_drv(1'b1);
        wr(ctrl_m);
        chk(st, 8'h00);
        $display("end of lin fault");
        // Supply, regulator and high side events
        for (int b = 5; b >= 2; b--)
        begin
            wr(8'h1e);
            n0 = irq_seen;
            sense[b + 2] <= 1'b1;
            chk_irq();
            chk(drive.highside_on, (b == 2) ? 8'h00 : 8'h07);
            wr(8'h02);
            chk(st, 8'h80 | 8'(1 << b));
            wr(8'h02);
            chk(st, 8'(1 << b));
            sense[b + 2] <= 1'b0;
        end
        wr(8'h1e);
        wr(8'h1e);
        chk_drv(1'b1);
        $display("end of status events");
        wr(8'he1);
        wr(8'he1);
        chk_drv(1'b0);
        n0 = irq_seen;
        lin_bus <= 1'b0;
        repeat (WAKE_N + 4) @(posedge clk);
        chk(rx_sense, 8'h00);
        lin_bus <= 1'b1;
        chk_irq();
        chk_drv(1'b1);
        wr(8'h02);
        chk(st, 8'hc0);
        wr(8'hc1);
        wr(8'hc1);
        chk_drv(1'b0);
        n0 = irq_seen;
        sense.wake_in_one <= 1'b1;
        chk_irq();
        wr(8'h02);
        chk(st, 8'h81);
        wr(8'h02);
        chk(st, 8'h01);
        $display("end of stop and wake");
        finish_test();
    end
endmodule

bind adspi_core adspi_core_sva u_sva (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ss_n(i_ss_n), .o_miso_oe(o_miso_oe),
    .i_tx_drive_pin(i_tx_drive_pin), .i_lin_bus(i_lin_bus), .o_rx_sense_pin(o_rx_sense_pin),
    .i_sense(i_sense), .o_drive(o_drive), .o_irq_n(o_irq_n)
);
